//--- logic/rx_lane_sync_bypass_port.sv
// Our own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Function
// - flag illegal metaframe control block type per lane
// - pulse one cycle when control bits change
// - pulse on bus rate unless retransmission on
// - word lock after 64 good framing patterns
// - lock counts sync and scrambler words as good framing, ignoring block type
// - twelve-bit word lock vector, one per lane
// - per-lane word available vector
// - resync request restarts word synchronisation
// - one 66-bit raw word bus per lane
// - one valid bit per lane word
// - per-lane discard flag for badly framed words
// - per-lane flag for metaframe sync words
// - per-lane receive buffer overflow flag
// - per-lane metaframe locked flag
module rx_lane_sync_bypass_port
   import rx_lane_pkg::*;
#(
   parameter int LBUS_DIV = 1
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [LANES-1:0] lane_in_valid,
   input wire logic [W-1:0] lane_in_block [LANES],
   input wire logic raw_read_request,
   input wire logic raw_resync_request,
   output logic [LANES-1:0] bad_block_type,
   output logic [LANES-1:0] word_lock,
   output logic control_bits_changed_pulse,
   output logic [MU_W-1:0] received_multiuse_control_bits,
   output logic [LANES-1:0] raw_word_available,
   output logic [W-1:0] raw_lane_word [LANES],
   output logic [LANES-1:0] raw_lane_word_valid,
   output logic [LANES-1:0] raw_word_discard,
   output logic [LANES-1:0] raw_word_is_frame_sync,
   output logic [LANES-1:0] raw_lane_buffer_overrun,
   output logic [LANES-1:0] raw_lane_frame_locked,
   output logic irq
);
   typedef struct packed {
      logic awready;
      logic wready;
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic byp_en;
      logic retx;
      logic resync;
      logic [LANES-1:0] bad_sticky;
      logic [IRQ_W-1:0] ist;
      logic [IRQ_W-1:0] ien;
      logic [MU_W-1:0] mu;
      logic mu_pend;
      logic mu_pulse;
      logic [15:0] tick_cnt;
      logic [LANES-1:0] wlock_prev;
      logic [LANES-1:0] ovr_prev;
      logic irq;
   } top_st_t;
   top_st_t s_q, s_d;

   // one clock domain, so every check below shares this clock and reset
   default clocking cb_sys @(posedge clk_sys);
   endclocking
   default disable iff (rst);

   lane_if li[LANES]();
   logic [LANES-1:0] v_wlock, v_flock, v_bad, v_ovr, v_avail;
   logic [LANES-1:0] v_val, v_disc, v_sync;

   // one lane engine per lane, all sharing the read and resync strobes
   genvar g;
   generate
      for (g = 0; g < LANES; g++)
      begin : g_lane
         assign li[g].in_valid = lane_in_valid[g];
         assign li[g].in_block = lane_in_block[g];
         assign li[g].resync = s_q.resync;
         assign li[g].rd = raw_read_request;
         assign li[g].byp_en = s_q.byp_en;
         assign v_wlock[g] = li[g].word_lock;
         assign v_flock[g] = li[g].frame_lock;
         assign v_bad[g] = li[g].bad_type;
         assign v_ovr[g] = li[g].overflow;
         assign v_avail[g] = li[g].avail;
         assign v_val[g] = li[g].out_valid;
         assign v_disc[g] = li[g].out_discard;
         assign v_sync[g] = li[g].out_sync;
         assign raw_lane_word[g] = li[g].out_word;
         rx_lane #(
            .LOCK_N(LOCK_COUNT),
            .SYNC_N(FRAME_SYNCS)
         ) u_lane (
            .clk_sys(clk_sys),
            .rst(rst),
            .bus(li[g])
         );
      end
   endgenerate

   logic [31:0] wmask;
   logic [31:0] wd;
   logic wr_go;
   logic [IRQ_W-1:0] ev;
   logic tick;
   logic mu_chg;

   always_comb
   begin
      wmask = {{8{s_q.w_strb[3]}}, {8{s_q.w_strb[2]}}, {8{s_q.w_strb[1]}}, {8{s_q.w_strb[0]}}};
      wd = s_q.w_data & wmask;
      wr_go = s_q.aw_have && s_q.w_have && !s_q.bvalid;
      tick = (s_q.tick_cnt == 16'(LBUS_DIV - 1));
      mu_chg = li[0].mu_valid && (li[0].mu != s_q.mu);
      ev[I_BAD] = |v_bad;
      ev[I_MU] = mu_chg;
      ev[I_OVR] = |(v_ovr & ~s_q.ovr_prev);
      ev[I_LOSS] = |(s_q.wlock_prev & ~v_wlock);
   end

   always_comb
   begin
      s_d = s_q;
      s_d.resync = raw_resync_request;
      s_d.wlock_prev = v_wlock;
      s_d.ovr_prev = v_ovr;
      // bus-rate divider; the pulse lands the cycle after its enable when retransmitting
      s_d.tick_cnt = tick ? 16'h0000 : s_q.tick_cnt + 16'h0001;
      // change detect on lane 0 control bits
      s_d.mu_pulse = 1'b0;
      if (s_q.mu_pend && (s_q.retx || tick))
      begin
         s_d.mu_pulse = 1'b1;
         s_d.mu_pend = 1'b0;
      end
      if (mu_chg)
      begin
         s_d.mu = li[0].mu;
         s_d.mu_pend = 1'b1;
      end
      // write address and data are taken in either order
      if (s_axi_awvalid && s_q.awready)
      begin
         s_d.aw_have = 1'b1;
         s_d.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_q.wready)
      begin
         s_d.w_have = 1'b1;
         s_d.w_data = s_axi_wdata;
         s_d.w_strb = s_axi_wstrb;
      end
      if (s_q.bvalid && s_axi_bready)
         s_d.bvalid = 1'b0;
      // sticky bad-type and interrupt status; a write clears, a new event wins
      if (wr_go)
      begin
         s_d.aw_have = 1'b0;
         s_d.w_have = 1'b0;
         s_d.bvalid = 1'b1;
         s_d.bresp = RESP_OKAY;
         case (s_q.aw_addr)
            A_CTRL:
            begin
               s_d.byp_en = (s_q.w_strb[0]) ? wd[C_BYP] : s_q.byp_en;
               s_d.retx = (s_q.w_strb[0]) ? wd[C_RETX] : s_q.retx;
               s_d.resync = raw_resync_request | wd[C_RESYNC];
            end
            A_BADTY: s_d.bad_sticky = s_q.bad_sticky & ~wd[LANES-1:0];
            A_ICLR: s_d.ist = s_q.ist & ~wd[IRQ_W-1:0];
            A_IEN: s_d.ien = (s_q.ien & ~wmask[IRQ_W-1:0]) | wd[IRQ_W-1:0];
            A_WLOCK, A_FLOCK, A_OVR, A_MU, A_IST: s_d.bresp = RESP_OKAY;
            default: s_d.bresp = RESP_SLVERR;
         endcase
      end
      s_d.bad_sticky = s_d.bad_sticky | v_bad;
      s_d.ist = s_d.ist | ev;
      s_d.awready = !s_d.aw_have && !s_d.bvalid;
      s_d.wready = !s_d.w_have && !s_d.bvalid;
      // read channel answers one cycle after the address is taken
      if (s_q.rvalid && s_axi_rready)
         s_d.rvalid = 1'b0;
      if (s_axi_arvalid && s_q.arready)
      begin
         s_d.rvalid = 1'b1;
         s_d.rresp = RESP_OKAY;
         s_d.rdata = 32'h0000_0000;
         case (s_axi_araddr)
            A_CTRL: s_d.rdata = {30'h0, s_q.retx, s_q.byp_en};
            A_WLOCK: s_d.rdata = {20'h0, v_wlock};
            A_FLOCK: s_d.rdata = {20'h0, v_flock};
            A_BADTY: s_d.rdata = {20'h0, s_q.bad_sticky};
            A_OVR: s_d.rdata = {20'h0, v_ovr};
            A_MU: s_d.rdata = {24'h0, s_q.mu};
            A_IST: s_d.rdata = {28'h0, s_q.ist};
            A_ICLR: s_d.rdata = 32'h0000_0000;
            A_IEN: s_d.rdata = {28'h0, s_q.ien};
            default: s_d.rresp = RESP_SLVERR;
         endcase
      end
      s_d.arready = !s_d.rvalid;
      // level interrupt from the next status, so it follows with no lag
      s_d.irq = |(s_d.ist & s_d.ien);
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // raw lane flags and status come straight from lane flops
   assign bad_block_type = v_bad;
   assign word_lock = v_wlock;
   assign raw_word_available = v_avail;
   assign raw_lane_word_valid = v_val;
   assign raw_word_discard = v_disc;
   assign raw_word_is_frame_sync = v_sync;
   assign raw_lane_buffer_overrun = v_ovr;
   assign raw_lane_frame_locked = v_flock;
   assign control_bits_changed_pulse = s_q.mu_pulse;
   assign received_multiuse_control_bits = s_q.mu;
   assign irq = s_q.irq;
   assign s_axi_awready = s_q.awready;
   assign s_axi_wready = s_q.wready;
   assign s_axi_bvalid = s_q.bvalid;
   assign s_axi_bresp = s_q.bresp;
   assign s_axi_arready = s_q.arready;
   assign s_axi_rvalid = s_q.rvalid;
   assign s_axi_rdata = s_q.rdata;
   assign s_axi_rresp = s_q.rresp;

   property p_pulse_one;
      @(posedge clk_sys) disable iff (rst)
      control_bits_changed_pulse && !s_q.mu_pend |=> !control_bits_changed_pulse;
   endproperty
   a_pulse_one: assert property (p_pulse_one) else $error("pulse longer than one cycle");

   property p_pulse_retx;
      @(posedge clk_sys) disable iff (rst)
      s_q.retx && !s_q.mu_pend && mu_chg && $stable(s_q.retx) |-> ##2 control_bits_changed_pulse;
   endproperty
   a_pulse_retx: assert property (p_pulse_retx) else $error("core-rate pulse late");

   property p_bad_sticky;
      @(posedge clk_sys) disable iff (rst)
      |bad_block_type |=> s_q.ist[I_BAD] && ((s_q.bad_sticky & $past(bad_block_type)) == $past(bad_block_type));
   endproperty
   a_bad_sticky: assert property (p_bad_sticky) else $error("bad type not kept");

   property p_avail_read;
      @(posedge clk_sys) disable iff (rst)
      raw_word_available[0] && raw_read_request |=> raw_lane_word_valid[0];
   endproperty
   a_avail_read: assert property (p_avail_read) else $error("available word not delivered");

   property p_bhold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");

   property p_rhold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");

   property p_wbusy;
      s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
   endproperty
   a_wbusy: assert property (p_wbusy) else $error("write taken while busy");

   property p_rbusy;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_rbusy: assert property (p_rbusy) else $error("read taken while busy");

   property p_pulse_rate;
      control_bits_changed_pulse |-> $past(s_q.retx) || $past(tick);
   endproperty
   a_pulse_rate: assert property (p_pulse_rate) else $error("pulse off its rate");

   property p_ovr_keep;
      !s_q.resync |=> (raw_lane_buffer_overrun & $past(raw_lane_buffer_overrun)) == $past(raw_lane_buffer_overrun);
   endproperty
   a_ovr_keep: assert property (p_ovr_keep) else $error("overrun lost");

   property p_valid_read;
      raw_lane_word_valid[0] |-> $past(raw_read_request) && $past(raw_word_available[0]);
   endproperty
   a_valid_read: assert property (p_valid_read) else $error("word without read");

   property p_event_kept;
      |ev |=> (s_q.ist & $past(ev)) == $past(ev);
   endproperty
   a_event_kept: assert property (p_event_kept) else $error("event lost to clear");

   property p_sync_flag;
      raw_word_is_frame_sync[0] |-> raw_lane_word[0][W-1:W-2] == FR_CTRL && raw_lane_word[0][63:58] == TY_SYNC;
   endproperty
   a_sync_flag: assert property (p_sync_flag) else $error("sync flag on other word");

   property p_discard;
      raw_word_discard[0] |-> raw_lane_word[0][W-1:W-2] != FR_DATA && raw_lane_word[0][W-1:W-2] != FR_CTRL;
   endproperty
   a_discard: assert property (p_discard) else $error("discard on good word");

   c_read: cover property (|raw_lane_word_valid);
   c_pulse: cover property (@(posedge clk_sys) disable iff (rst) control_bits_changed_pulse);
   c_irq: cover property (@(posedge clk_sys) disable iff (rst) $rose(irq));
endmodule // rx_lane_sync_bypass_port

//--- logic/rx_lane_pkg.sv
package rx_lane_pkg;
   localparam int LANES = 12;
   localparam int W = 66;
   localparam int MU_W = 8;
   localparam int IRQ_W = 4;
   // consecutive good framing patterns needed for word lock
   localparam logic [6:0] LOCK_COUNT = 7'h40;
   // sync words seen before the lane counts as metaframe locked
   localparam logic [2:0] FRAME_SYNCS = 3'h4;
   // framing patterns in bits 65:64
   localparam logic [1:0] FR_DATA = 2'h1;
   localparam logic [1:0] FR_CTRL = 2'h2;
   // metaframe control word block types in bits 63:58
   localparam logic [5:0] TY_SYNC = 6'h1e;
   localparam logic [5:0] TY_SCRAM = 6'h0a;
   localparam logic [5:0] TY_SKIP = 6'h07;
   localparam logic [5:0] TY_DIAG = 6'h19;
   localparam int MU_LSB = 48;
   // register byte offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_WLOCK = 8'h04;
   localparam logic [7:0] A_FLOCK = 8'h08;
   localparam logic [7:0] A_BADTY = 8'h0c;
   localparam logic [7:0] A_OVR = 8'h10;
   localparam logic [7:0] A_MU = 8'h14;
   localparam logic [7:0] A_IST = 8'h18;
   localparam logic [7:0] A_ICLR = 8'h1c;
   localparam logic [7:0] A_IEN = 8'h20;
   // control bits
   localparam int C_BYP = 0;
   localparam int C_RETX = 1;
   localparam int C_RESYNC = 2;
   // interrupt bits
   localparam int I_BAD = 0;
   localparam int I_MU = 1;
   localparam int I_OVR = 2;
   localparam int I_LOSS = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/lane_if.sv
`timescale 1ns/1ps
interface lane_if;
   import rx_lane_pkg::*;
   logic in_valid;
   logic [W-1:0] in_block;
   logic resync;
   logic rd;
   logic byp_en;
   logic word_lock;
   logic frame_lock;
   logic bad_type;
   logic overflow;
   logic avail;
   logic out_valid;
   logic out_discard;
   logic out_sync;
   logic [W-1:0] out_word;
   logic mu_valid;
   logic [MU_W-1:0] mu;
   modport lane (input in_valid, in_block, resync, rd, byp_en,
      output word_lock, frame_lock, bad_type, overflow, avail, out_valid,
      out_discard, out_sync, out_word, mu_valid, mu);
   modport top (output in_valid, in_block, resync, rd, byp_en,
      input word_lock, frame_lock, bad_type, overflow, avail, out_valid,
      out_discard, out_sync, out_word, mu_valid, mu);
endinterface // lane_if

//--- logic/rx_lane.sv
`timescale 1ns/1ps
module rx_lane
   import rx_lane_pkg::*;
#(
   parameter logic [6:0] LOCK_N = LOCK_COUNT,
   parameter logic [2:0] SYNC_N = FRAME_SYNCS
)
(
   input wire logic clk_sys,
   input wire logic rst,
   lane_if.lane bus
);
   typedef struct packed {
      logic s1_v;
      logic [W-1:0] s1_b;
      logic s2_v;
      logic [W-1:0] s2_b;
      logic [6:0] cnt;
      logic word_lock;
      logic [2:0] fcnt;
      logic frame_lock;
      logic bad_type;
      logic hold_v;
      logic [W-1:0] hold_b;
      logic hold_disc;
      logic hold_sync;
      logic overflow;
      logic out_v;
      logic [W-1:0] out_w;
      logic out_disc;
      logic out_sync;
      logic mu_v;
      logic [MU_W-1:0] mu;
   } lane_st_t;
   lane_st_t s_q, s_d;
   logic [1:0] fr;
   logic [5:0] ty;
   logic good, meta, is_sync, legal;

   // lane word decode on the synchronised stage only
   always_comb
   begin
      fr = s_q.s2_b[W-1:W-2];
      ty = s_q.s2_b[63:58];
      good = (fr == FR_DATA) || (fr == FR_CTRL);
      meta = (fr == FR_CTRL) && !s_q.s2_b[63];
      is_sync = meta && (ty == TY_SYNC);
      legal = (ty == TY_SYNC) || (ty == TY_SCRAM) || (ty == TY_SKIP) || (ty == TY_DIAG);
   end

   always_comb
   begin
      s_d = s_q;
      // two flops: raw serdes words come from another domain
      s_d.s1_v = bus.in_valid;
      s_d.s1_b = bus.in_block;
      s_d.s2_v = s_q.s1_v;
      s_d.s2_b = s_q.s1_b;
      s_d.bad_type = 1'b0;
      s_d.out_v = 1'b0;
      s_d.mu_v = 1'b0;
      // a read pops the holding word; reader ignores lanes with valid low
      if (bus.rd && s_q.hold_v)
      begin
         s_d.out_v = 1'b1;
         s_d.out_w = s_q.hold_b;
         s_d.out_disc = s_q.hold_disc;
         s_d.out_sync = s_q.hold_sync;
         s_d.hold_v = 1'b0;
      end
      if (bus.resync)
      begin
         s_d.cnt = 7'h00;
         s_d.word_lock = 1'b0;
         s_d.fcnt = 3'h0;
         s_d.frame_lock = 1'b0;
         s_d.hold_v = 1'b0;
         s_d.overflow = 1'b0;
      end
      else if (s_q.s2_v)
      begin
         // lock looks at framing bits only, never at block types
         if (good)
         begin
            if (s_q.cnt != LOCK_N)
               s_d.cnt = s_q.cnt + 7'h01;
            if (s_q.cnt == LOCK_N - 7'h01)
               s_d.word_lock = 1'b1;
         end
         else
         begin
            s_d.cnt = 7'h00;
            s_d.word_lock = 1'b0;
            s_d.fcnt = 3'h0;
            s_d.frame_lock = 1'b0;
         end
         if (s_q.word_lock)
         begin
            s_d.bad_type = meta && !legal;
            if (is_sync && (s_q.fcnt != SYNC_N))
               s_d.fcnt = s_q.fcnt + 3'h1;
            if (is_sync && (s_q.fcnt == SYNC_N - 3'h1))
               s_d.frame_lock = 1'b1;
            if ((fr == FR_CTRL) && s_q.s2_b[63])
            begin
               s_d.mu_v = 1'b1;
               s_d.mu = s_q.s2_b[MU_LSB+MU_W-1:MU_LSB];
            end
            // single holding word; a second word while full is lost
            if (bus.byp_en)
            begin
               if (s_d.hold_v)
                  s_d.overflow = 1'b1;
               else
               begin
                  s_d.hold_v = 1'b1;
                  s_d.hold_b = s_q.s2_b;
                  s_d.hold_disc = !good;
                  s_d.hold_sync = is_sync;
               end
            end
         end
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (rst)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   assign bus.word_lock = s_q.word_lock;
   assign bus.frame_lock = s_q.frame_lock;
   assign bus.bad_type = s_q.bad_type;
   assign bus.overflow = s_q.overflow;
   assign bus.avail = s_q.hold_v;
   assign bus.out_valid = s_q.out_v;
   assign bus.out_word = s_q.out_w;
   assign bus.out_discard = s_q.out_disc;
   assign bus.out_sync = s_q.out_sync;
   assign bus.mu_valid = s_q.mu_v;
   assign bus.mu = s_q.mu;

   property p_lock_count;
      @(posedge clk_sys) disable iff (rst)
      $rose(s_q.word_lock) |-> $past(s_q.cnt) == LOCK_N - 7'h01;
   endproperty
   a_lock_count: assert property (p_lock_count) else $error("lock without full count");

   property p_resync;
      @(posedge clk_sys) disable iff (rst)
      bus.resync |=> !s_q.word_lock && !s_q.frame_lock && !s_q.hold_v && !s_q.overflow;
   endproperty
   a_resync: assert property (p_resync) else $error("resync did not restart lane");

   property p_read;
      @(posedge clk_sys) disable iff (rst)
      bus.rd && s_q.hold_v |=> s_q.out_v && s_q.out_w == $past(s_q.hold_b);
   endproperty
   a_read: assert property (p_read) else $error("read word not presented");

   property p_overflow;
      @(posedge clk_sys) disable iff (rst)
      s_q.hold_v && !bus.rd && s_q.s2_v && s_q.word_lock && bus.byp_en && !bus.resync |=> s_q.overflow;
   endproperty
   a_overflow: assert property (p_overflow) else $error("overflow missed");

   property p_frame;
      @(posedge clk_sys) disable iff (rst)
      s_q.frame_lock |-> s_q.word_lock;
   endproperty
   a_frame: assert property (p_frame) else $error("frame lock without word lock");

   c_lock: cover property (@(posedge clk_sys) disable iff (rst) $rose(s_q.word_lock));
   c_ovr: cover property (@(posedge clk_sys) disable iff (rst) $rose(s_q.overflow));
endmodule // rx_lane

//--- testbench/raw_reader.sv
`timescale 1ns/1ps
module raw_reader
   import rx_lane_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic en,
   input wire logic [LANES-1:0] avail,
   input wire logic [LANES-1:0] word_valid,
   output logic raw_read_request,
   output logic [31:0] reads
);
   // one-cycle read pulse only while a word waits; en lets the bench stall us
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         raw_read_request <= 1'b0;
         reads <= 32'h0;
      end
      else
      begin
         raw_read_request <= en && (|avail) && !raw_read_request;
         if (word_valid[0])
         begin
            reads <= reads + 32'h1;
         end
      end
   end
endmodule // raw_reader

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(got, exp) \
   begin \
      check_count++; \
      if ((got) !== (exp)) \
      begin \
         num_errors++; \
         $display("[ERR] %0t got %0h expected %0h", $time, (got), (exp)); \
      end \
   end
module tb_top
   import rx_lane_pkg::*;
;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, mu_pulse, irq, rd_req;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, reads;
   logic [LANES-1:0] lane_vld = '0;
   logic [W-1:0] lane_blk [LANES];
   logic resync = 1'b0;
   logic reader_en = 1'b0;
   logic [LANES-1:0] bad_ty, wlock, avail, rvld, rdisc, rsync, rovr, rflock;
   logic [MU_W-1:0] mu_bits, mu_exp, v;
   logic [W-1:0] rword [LANES];
   logic [31:0] seed = 32'h62; // xorshift state, starts at 98
   logic [31:0] d;
   logic [1:0] r;
   int num_errors = 0;
   int check_count = 0;
   int n;

   // 20 ns clock
   always #10 clk_sys = ~clk_sys;

   rx_lane_sync_bypass_port #(.LBUS_DIV(3)) u_dut (.clk_sys(clk_sys), .rst(rst),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
      .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .lane_in_valid(lane_vld), .lane_in_block(lane_blk),
      .raw_read_request(rd_req), .raw_resync_request(resync), .bad_block_type(bad_ty),
      .word_lock(wlock), .control_bits_changed_pulse(mu_pulse), .received_multiuse_control_bits(mu_bits),
      .raw_word_available(avail), .raw_lane_word(rword), .raw_lane_word_valid(rvld),
      .raw_word_discard(rdisc), .raw_word_is_frame_sync(rsync), .raw_lane_buffer_overrun(rovr),
      .raw_lane_frame_locked(rflock), .irq(irq));

   // user logic on the far side of the bypass port
   raw_reader u_reader (.clk_sys(clk_sys), .rst(rst), .en(reader_en), .avail(avail), .word_valid(rvld),
      .raw_read_request(rd_req), .reads(reads));

   function automatic logic [31:0] next_rand();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [W-1:0] ctrl_word(input logic [5:0] ty);
      return {FR_CTRL, ty, 58'h0};
   endfunction
   function automatic logic [W-1:0] mu_word(input logic [7:0] bits);
      return {FR_CTRL, 8'h80, bits, 48'h0};
   endfunction
   function automatic logic [LANES-1:0] exp_sync(input logic [W-1:0] w);
      return (w[65:64] == FR_CTRL && w[63:58] == TY_SYNC) ? '1 : '0;
   endfunction

   task automatic test_done();
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // same word on every lane, back to back while called in a row
   task automatic send(input logic [W-1:0] w);
      @(posedge clk_sys);
      lane_vld <= '1;
      for (int i = 0; i < LANES; i++)
         lane_blk[i] <= w;
   endtask
   // ends on a falling edge so outputs are settled for compares
   task automatic idle(input int cyc);
      @(posedge clk_sys);
      lane_vld <= '0;
      repeat (cyc) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] dat, output logic [1:0] resp);
      bit aw_ok, w_ok;
      @(posedge clk_sys);
      awaddr <= a;
      awvalid <= 1'b1;
      wdata <= dat;
      wvalid <= 1'b1;
      bready <= 1'b1;
      aw_ok = 0;
      w_ok = 0;
      while (!(aw_ok && w_ok))
      begin
         @(posedge clk_sys);
         if (awready && !aw_ok)
         begin
            aw_ok = 1;
            awvalid <= 1'b0;
         end
         if (wready && !w_ok)
         begin
            w_ok = 1;
            wvalid <= 1'b0;
         end
      end
      while (bvalid !== 1'b1)
         @(posedge clk_sys);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] dat, output logic [1:0] resp);
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_sys); while (arready !== 1'b1);
      arvalid <= 1'b0;
      while (rvalid !== 1'b1)
         @(posedge clk_sys);
      dat = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // counts cycles a pulse output stands high
   task automatic pulses(input bit ctl, output int cnt);
      cnt = 0;
      repeat (12)
      begin
         @(negedge clk_sys);
         if ((ctl ? mu_pulse : bad_ty[0]) === 1'b1)
            cnt++;
      end
   endtask
   task automatic lock_up(input int cnt);
      repeat (cnt) send({FR_DATA, next_rand(), next_rand()});
   endtask
   // one word through the bypass port, checked against what was sent
   task automatic deliver(input logic [W-1:0] w);
      int k;
      send(w);
      idle(0);
      for (k = 0; k < 20 && rvld[0] !== 1'b1; k++)
         @(negedge clk_sys);
      `CHK(rvld, {LANES{1'b1}})
      `CHK(rword[0], w)
      `CHK(rword[LANES-1], w)
      `CHK(rdisc, {LANES{1'b0}})
      `CHK(rsync, exp_sync(w))
   endtask

   // hang guard, well beyond the few hundred cycles the tests need
   initial
   begin
      repeat (20000) @(posedge clk_sys);
      num_errors++;
      $display("[ERR] %0t watchdog expired", $time);
      test_done();
   end

   // main sequence
   initial
   begin
      for (int i = 0; i < LANES; i++)
         lane_blk[i] = '0;
      repeat (5) @(posedge clk_sys);
      rst <= 1'b0;
      rd(A_CTRL, d, r);
      `CHK(d, 32'h0)
      rd(8'h40, d, r);
      `CHK(r, RESP_SLVERR)
      wr(8'h44, 32'h1, r);
      `CHK(r, RESP_SLVERR)
      wr(A_IEN, 32'h1, r);
      wr(A_CTRL, 32'h1, r);
      rd(A_IEN, d, r);
      `CHK(d, 32'h1)
      $display("register test done");
      lock_up(63);
      idle(6);
      `CHK(wlock, {LANES{1'b0}})
      lock_up(1);
      idle(6);
      `CHK(wlock, {LANES{1'b1}})
      lock_up(2);
      idle(4);
      `CHK(avail, {LANES{1'b1}})
      `CHK(rovr, {LANES{1'b1}})
      @(posedge clk_sys);
      resync <= 1'b1;
      @(posedge clk_sys);
      resync <= 1'b0;
      idle(4);
      `CHK(wlock, {LANES{1'b0}})
      `CHK(rovr, {LANES{1'b0}})
      lock_up(64);
      idle(6);
      `CHK(wlock, {LANES{1'b1}})
      reader_en <= 1'b1;
      idle(8);
      $display("word lock test done");
      for (int k = 0; k < 10; k++)
         deliver(k < 6 ? {FR_DATA, next_rand(), next_rand()} : ctrl_word(TY_SYNC));
      `CHK(rflock, {LANES{1'b1}})
      $display("bypass test done");
      send(ctrl_word(6'h11));
      idle(0);
      `CHK(reads, 32'ha)
      pulses(0, n);
      `CHK(n, 1)
      `CHK(irq, 1'b1)
      wr(A_ICLR, 32'h1, r);
      idle(3);
      `CHK(irq, 1'b0)
      wr(A_IEN, 32'h0, r);
      send(ctrl_word(6'h11));
      idle(0);
      pulses(0, n);
      `CHK(n, 1)
      `CHK(irq, 1'b0)
      rd(A_IST, d, r);
      `CHK(d[I_BAD], 1'b1)
      $display("bad type test done");
      mu_exp = '0;
      for (int retx = 0; retx < 2; retx++)
      begin
         wr(A_CTRL, {30'h0, retx[0], 1'b1}, r);
         d = next_rand();
         v = mu_exp ^ (d[7:0] | 8'h01);
         send(mu_word(v));
         idle(0);
         pulses(1, n);
         `CHK(n, 1)
         `CHK(mu_bits, v)
         mu_exp = v;
         send(mu_word(v));
         idle(0);
         pulses(1, n);
         `CHK(n, 0)
      end
      $display("control bits test done");
      send({2'b00, 64'h0});
      idle(6);
      `CHK(wlock, {LANES{1'b0}})
      `CHK(rdisc, {LANES{1'b1}})
      $display("framing loss test done");
      test_done();
   end
endmodule // tb_top
